// ### rtl/bmf_pkg.sv
/*
 Shared constants and types of the bus-matching dual queue with mailboxes.
 Assumes a single system clock; port clocks arrive as sampled pins.
*/
package bmf_pkg;

   // ***********************************************
   // Widths and stage depth
   // ***********************************************
   localparam int BMF_LONG_W   = 36;
   localparam int BMF_NARROW_W = 18;
   localparam int BMF_BYTE_W   = 9;
   localparam int BMF_STAGE_DEPTH = 4;

   // ***********************************************
   // Sub-word indices and reset values
   // ***********************************************
   localparam logic [1:0] BMF_LAST_WORD = 2'h1;
   localparam logic [1:0] BMF_LAST_BYTE = 2'h3;
   localparam logic BMF_AE_RESET  = 1'h0;
   localparam logic BMF_AF_RESET  = 1'h1;
   localparam logic BMF_MBX_RESET = 1'h1;
   localparam logic BMF_OE_RESET  = 1'h1;

   typedef enum logic {
      BMF_SIZE_WORD = 1'b0,
      BMF_SIZE_BYTE = 1'b1
   } bmf_size_t;

   // Every pin that passes the input synchroniser
   typedef struct packed {
      logic                    a_clk;
      logic                    b_clk;
      logic                    c_clk;
      logic                    a_sel_n;
      logic                    a_dir;
      logic                    a_mbx;
      logic                    a_en;
      logic                    b_sel_n;
      logic                    b_mbx;
      logic                    b_en;
      logic                    c_mbx;
      logic                    c_en;
      logic [BMF_LONG_W-1:0]   a_data;
      logic [BMF_NARROW_W-1:0] c_data;
   } bmf_pins_t;

endpackage

// ### rtl/bmf_queue.sv
/*
 Stage FIFO and the bus-matching dual queue with two mailboxes.
 Assumes port clocks and pins are asynchronous to CLK_SYS_IN and much slower.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Narrow port B: B almost-empty falls on the read of a long word's last piece.
// - A almost-empty rises on the port-A edge after the enabling port-C write.
// - Narrow port C: only the last piece's write counts for A almost-empty.
// - A almost-full rises on the port-A edge after the enabling port-B read.
// - Narrow port B: only the last piece's read counts for A almost-full.
// - C almost-full rises on the port-C edge after the enabling port-A read.
// - Narrow port C: C almost-full falls on the write completing a long word.
// - Word B: mailbox A-to-B takes A[17:0], shows on B[17:0].
// - Byte B: mailbox A-to-B takes A[8:0], shows on B[8:0].
// - Word C: mailbox C-to-A takes C[17:0], shows on A[35:18].
// - Byte C: mailbox C-to-A takes C[8:0], shows on A[26:18].
// - Depth is 256, 512 or 1024; almost-full measured from it.
// - B almost-empty rises on the port-B edge after the enabling port-A write.

module bmf_stage_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("Stage depth must be a power of two");

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_out = cnt_reg != '0;
   assign out_data_out  = mem[rd_reg];
   assign push = ce_in & in_valid_in & in_ready_out;
   assign pop  = ce_in & out_valid_out & out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_reg + AW'(push);
         rd_reg  <= rd_reg + AW'(pop);
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module bmf_queue
   import bmf_pkg::*;
#(
   parameter int DEPTH = 256
) (
   input  wire logic                              CLK_SYS_IN,
   input  wire logic                              RESET_IN,
   input  wire logic                              CE_IN,
   input  wire logic                              PORT_A_CLOCK_IN,
   input  wire logic                              PORT_A_SELECT_N_IN,
   input  wire logic                              PORT_A_DIRECTION_IN,
   input  wire logic                              PORT_A_MAILBOX_SELECT_IN,
   input  wire logic                              PORT_A_ENABLE_IN,
   input  wire logic [BMF_LONG_W-1:0]             PORT_A_DATA_IN,
   output logic [BMF_LONG_W-1:0]                  PORT_A_DATA_OUT,
   output logic                                   PORT_A_DATA_OE_N_OUT,
   input  wire logic                              PORT_B_CLOCK_IN,
   input  wire logic                              PORT_B_SELECT_N_IN,
   input  wire logic                              PORT_B_MAILBOX_SELECT_IN,
   input  wire logic                              PORT_B_ENABLE_IN,
   input  wire bmf_size_t                         PORT_B_SIZE_IN,
   output logic [BMF_NARROW_W-1:0]                PORT_B_DATA_OUT,
   input  wire logic                              PORT_C_CLOCK_IN,
   input  wire logic                              PORT_C_MAILBOX_SELECT_IN,
   input  wire logic                              PORT_C_ENABLE_IN,
   input  wire bmf_size_t                         PORT_C_SIZE_IN,
   input  wire logic [BMF_NARROW_W-1:0]           PORT_C_DATA_IN,
   input  wire logic [$clog2(DEPTH):0]            ALMOST_EMPTY_OFFSET_IN,
   input  wire logic [$clog2(DEPTH):0]            ALMOST_FULL_OFFSET_IN,
   output logic                                   PORT_B_ALMOST_EMPTY_N_OUT,
   output logic                                   PORT_A_ALMOST_EMPTY_N_OUT,
   output logic                                   PORT_A_ALMOST_FULL_N_OUT,
   output logic                                   PORT_C_ALMOST_FULL_N_OUT,
   output logic                                   MAILBOX_AB_FULL_N_OUT,
   output logic                                   MAILBOX_CA_FULL_N_OUT
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = AW + 1;
   localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);
   if (DEPTH != 256 && DEPTH != 512 && DEPTH != 1024) $error("Depth must be 256, 512 or 1024");

   function automatic logic [1:0] f_last(input bmf_size_t s);
      f_last = (s == BMF_SIZE_BYTE) ? BMF_LAST_BYTE : BMF_LAST_WORD;
   endfunction

   // Flag stays high while the level is above the offset
   function automatic logic f_above(input logic [LW-1:0] lvl, input logic [LW-1:0] off);
      f_above = lvl > off;
   endfunction

   // ***********************************************
   // Pin synchroniser and port clock edges
   // ***********************************************
   bmf_pins_t   pins;
   bmf_pins_t   pin_s1_reg;
   bmf_pins_t   pin_s2_reg;
   bmf_pins_t   pin_s3_reg;
   logic [2:0]  clk_s2;
   logic [2:0]  clk_s3;
   logic [2:0]  clk_filt_reg;
   logic [2:0]  edge_ev;
   logic        a_edge;
   logic        b_edge;
   logic        c_edge;

   assign pins = '{a_clk: PORT_A_CLOCK_IN, b_clk: PORT_B_CLOCK_IN, c_clk: PORT_C_CLOCK_IN,
                   a_sel_n: PORT_A_SELECT_N_IN, a_dir: PORT_A_DIRECTION_IN,
                   a_mbx: PORT_A_MAILBOX_SELECT_IN, a_en: PORT_A_ENABLE_IN,
                   b_sel_n: PORT_B_SELECT_N_IN, b_mbx: PORT_B_MAILBOX_SELECT_IN,
                   b_en: PORT_B_ENABLE_IN, c_mbx: PORT_C_MAILBOX_SELECT_IN,
                   c_en: PORT_C_ENABLE_IN, a_data: PORT_A_DATA_IN, c_data: PORT_C_DATA_IN};

   // Data moves through the same stages as the clocks so it stays aligned
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
      end else if (CE_IN) begin
         pin_s1_reg <= pins;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   assign clk_s2  = {pin_s2_reg.c_clk, pin_s2_reg.b_clk, pin_s2_reg.a_clk};
   assign clk_s3  = {pin_s3_reg.c_clk, pin_s3_reg.b_clk, pin_s3_reg.a_clk};
   assign edge_ev = ~(clk_s2 ^ clk_s3) & clk_s3 & ~clk_filt_reg;
   assign a_edge  = edge_ev[0];
   assign b_edge  = edge_ev[1];
   assign c_edge  = edge_ev[2];

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         clk_filt_reg <= '0;
      end else if (CE_IN) begin
         for (int i = 0; i < 3; i++) begin
            if (clk_s2[i] == clk_s3[i]) begin
               clk_filt_reg[i] <= clk_s3[i];
            end
         end
      end
   end

   // ***********************************************
   // Access decode
   // ***********************************************
   bmf_pins_t       p;
   logic [LW-1:0]   ab_level_reg;
   logic [LW-1:0]   ca_level_reg;
   logic [1:0]      b_sub_reg;
   logic [1:0]      c_sub_reg;
   logic            st_out_valid;
   logic            a_wr;
   logic            a_rd;
   logic            a_push;
   logic            a_pop;
   logic            a_mbx_wr;
   logic            a_mbx_rd;
   logic            b_rd;
   logic            b_take;
   logic            b_fin;
   logic            b_mbx_rd;
   logic            c_take;
   logic            c_fin;
   logic            c_push;
   logic            c_mbx_wr;

   assign p        = pin_s3_reg;
   assign a_wr     = a_edge & ~p.a_sel_n & p.a_en & p.a_dir;
   assign a_rd     = a_edge & ~p.a_sel_n & p.a_en & ~p.a_dir;
   assign a_push   = a_wr & ~p.a_mbx & (ab_level_reg < DEPTH_L);
   assign a_mbx_wr = a_wr & p.a_mbx;
   assign a_pop    = a_rd & ~p.a_mbx & (ca_level_reg != '0);
   assign a_mbx_rd = a_rd & p.a_mbx;
   assign b_rd     = b_edge & ~p.b_sel_n & p.b_en;
   assign b_take   = b_rd & ~p.b_mbx & st_out_valid;
   assign b_fin    = b_take & (b_sub_reg == f_last(PORT_B_SIZE_IN));
   assign b_mbx_rd = b_rd & p.b_mbx;
   assign c_take   = c_edge & p.c_en & ~p.c_mbx;
   assign c_fin    = c_take & (c_sub_reg == f_last(PORT_C_SIZE_IN));
   assign c_push   = c_fin & (ca_level_reg < DEPTH_L);
   assign c_mbx_wr = c_edge & p.c_en & p.c_mbx;

   // ***********************************************
   // Queue A to B: main store, stage FIFO, levels
   // ***********************************************
   logic [BMF_LONG_W-1:0] ab_mem [DEPTH];
   logic [AW-1:0]         ab_wr_reg;
   logic [AW-1:0]         ab_rd_reg;
   logic [LW-1:0]         ab_mcnt_reg;
   logic                  st_in_ready;
   logic                  ab_mem_pop;
   logic [BMF_LONG_W-1:0] st_out_data;
   logic [LW-1:0]         ab_level_next;

   assign ab_mem_pop    = CE_IN & (ab_mcnt_reg != '0) & st_in_ready;
   assign ab_level_next = ab_level_reg + LW'(a_push) - LW'(b_fin);

   always_ff @(posedge CLK_SYS_IN) begin
      if (CE_IN && a_push) begin
         ab_mem[ab_wr_reg] <= p.a_data;
      end
   end

   // Level counts stage words too, so flags see everything not yet read on B
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         ab_wr_reg    <= '0;
         ab_rd_reg    <= '0;
         ab_mcnt_reg  <= '0;
         ab_level_reg <= '0;
      end else if (CE_IN) begin
         ab_wr_reg    <= ab_wr_reg + AW'(a_push);
         ab_rd_reg    <= ab_rd_reg + AW'(ab_mem_pop);
         ab_mcnt_reg  <= ab_mcnt_reg + LW'(a_push) - LW'(ab_mem_pop);
         ab_level_reg <= ab_level_next;
      end
   end

   // Prefetch keeps port B from waiting on the main store
   bmf_stage_fifo #(
      .WIDTH (BMF_LONG_W),
      .DEPTH (BMF_STAGE_DEPTH)
   ) u_stage (
      .clk_in        (CLK_SYS_IN),
      .rst_in        (RESET_IN),
      .ce_in         (CE_IN),
      .in_valid_in   (ab_mcnt_reg != '0),
      .in_ready_out  (st_in_ready),
      .in_data_in    (ab_mem[ab_rd_reg]),
      .out_valid_out (st_out_valid),
      .out_ready_in  (b_fin),
      .out_data_out  (st_out_data)
   );

   // ***********************************************
   // Queue C to A: word assembly, store, levels
   // ***********************************************
   logic [BMF_LONG_W-1:0] ca_mem [DEPTH];
   logic [AW-1:0]         ca_wr_reg;
   logic [AW-1:0]         ca_rd_reg;
   logic [BMF_LONG_W-1:0] c_acc_reg;
   logic [BMF_LONG_W-1:0] c_long;
   logic [LW-1:0]         ca_level_next;

   // Little-endian: first piece lands in the low lanes
   always_comb begin
      c_long = c_acc_reg;
      if (PORT_C_SIZE_IN == BMF_SIZE_BYTE) begin
         c_long[BMF_BYTE_W*c_sub_reg +: BMF_BYTE_W] = p.c_data[BMF_BYTE_W-1:0];
      end else begin
         c_long[BMF_NARROW_W*c_sub_reg[0] +: BMF_NARROW_W] = p.c_data;
      end
   end

   assign ca_level_next = ca_level_reg + LW'(c_push) - LW'(a_pop);

   always_ff @(posedge CLK_SYS_IN) begin
      if (CE_IN && c_push) begin
         ca_mem[ca_wr_reg] <= c_long;
      end
   end

   // A full queue drops the completed long word; sub-counters still wrap
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         ca_wr_reg    <= '0;
         ca_rd_reg    <= '0;
         ca_level_reg <= '0;
         c_acc_reg    <= '0;
         c_sub_reg    <= '0;
         b_sub_reg    <= '0;
      end else if (CE_IN) begin
         ca_wr_reg    <= ca_wr_reg + AW'(c_push);
         ca_rd_reg    <= ca_rd_reg + AW'(a_pop);
         ca_level_reg <= ca_level_next;
         if (c_take) begin
            c_acc_reg <= c_long;
            c_sub_reg <= c_fin ? 2'h0 : c_sub_reg + 2'h1;
         end
         if (b_take) begin
            b_sub_reg <= b_fin ? 2'h0 : b_sub_reg + 2'h1;
         end
      end
   end

   // ***********************************************
   // Almost flags, each updated on its owner's edge
   // ***********************************************
   // Far-side changes reach a flag only at the owner's next edge; the pin
   // synchroniser supplies the crossing, so no extra stage is added here.
   logic [LW-1:0] af_mark;

   assign af_mark = DEPTH_L - ALMOST_FULL_OFFSET_IN;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         PORT_B_ALMOST_EMPTY_N_OUT <= BMF_AE_RESET;
         PORT_A_ALMOST_EMPTY_N_OUT <= BMF_AE_RESET;
         PORT_A_ALMOST_FULL_N_OUT  <= BMF_AF_RESET;
         PORT_C_ALMOST_FULL_N_OUT  <= BMF_AF_RESET;
      end else if (CE_IN) begin
         if (b_edge) begin
            PORT_B_ALMOST_EMPTY_N_OUT <= f_above(ab_level_next, ALMOST_EMPTY_OFFSET_IN);
         end
         if (a_edge) begin
            PORT_A_ALMOST_EMPTY_N_OUT <= f_above(ca_level_next, ALMOST_EMPTY_OFFSET_IN);
            PORT_A_ALMOST_FULL_N_OUT  <= ab_level_next < af_mark;
         end
         if (c_edge) begin
            PORT_C_ALMOST_FULL_N_OUT  <= ca_level_next < af_mark;
         end
      end
   end

   // ***********************************************
   // Mailboxes and port data outputs
   // ***********************************************
   logic [BMF_NARROW_W-1:0] mailbox_ab_reg;
   logic [BMF_NARROW_W-1:0] mailbox_ca_reg;

   // Write beats read on the same edge so new mail is never lost
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         mailbox_ab_reg        <= '0;
         mailbox_ca_reg        <= '0;
         MAILBOX_AB_FULL_N_OUT <= BMF_MBX_RESET;
         MAILBOX_CA_FULL_N_OUT <= BMF_MBX_RESET;
      end else if (CE_IN) begin
         if (a_mbx_wr) begin
            mailbox_ab_reg <= (PORT_B_SIZE_IN == BMF_SIZE_BYTE) ?
               {9'h0, p.a_data[BMF_BYTE_W-1:0]} : p.a_data[BMF_NARROW_W-1:0];
            MAILBOX_AB_FULL_N_OUT <= 1'b0;
         end else if (b_mbx_rd) begin
            MAILBOX_AB_FULL_N_OUT <= 1'b1;
         end
         if (c_mbx_wr) begin
            mailbox_ca_reg <= (PORT_C_SIZE_IN == BMF_SIZE_BYTE) ?
               {9'h0, p.c_data[BMF_BYTE_W-1:0]} : p.c_data;
            MAILBOX_CA_FULL_N_OUT <= 1'b0;
         end else if (a_mbx_rd) begin
            MAILBOX_CA_FULL_N_OUT <= 1'b1;
         end
      end
   end

   // Undefined lanes read as zero
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         PORT_A_DATA_OUT      <= '0;
         PORT_A_DATA_OE_N_OUT <= BMF_OE_RESET;
         PORT_B_DATA_OUT      <= '0;
      end else if (CE_IN) begin
         if (a_edge) begin
            PORT_A_DATA_OE_N_OUT <= p.a_sel_n | p.a_dir;
         end
         if (a_pop) begin
            PORT_A_DATA_OUT <= ca_mem[ca_rd_reg];
         end else if (a_mbx_rd) begin
            PORT_A_DATA_OUT <= {mailbox_ca_reg, 18'h0};
         end
         if (b_take) begin
            PORT_B_DATA_OUT <= (PORT_B_SIZE_IN == BMF_SIZE_BYTE) ?
               {9'h0, st_out_data[BMF_BYTE_W*b_sub_reg +: BMF_BYTE_W]} :
               st_out_data[BMF_NARROW_W*b_sub_reg[0] +: BMF_NARROW_W];
         end else if (b_mbx_rd) begin
            PORT_B_DATA_OUT <= mailbox_ab_reg;
         end
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN || !CE_IN);

   property p_aeb_falls;
      b_fin && !f_above(ab_level_next, ALMOST_EMPTY_OFFSET_IN) |=> !PORT_B_ALMOST_EMPTY_N_OUT;
   endproperty
   a_aeb_falls: assert property (p_aeb_falls) else $error("B almost-empty not low");

   property p_aeb_rise;
      $rose(PORT_B_ALMOST_EMPTY_N_OUT) |-> $past(b_edge);
   endproperty
   a_aeb_rise: assert property (p_aeb_rise) else $error("B almost-empty rose off a B edge");

   property p_aea_rise;
      $rose(PORT_A_ALMOST_EMPTY_N_OUT) |->
         $past(a_edge) && $past(ca_level_next) > $past(ALMOST_EMPTY_OFFSET_IN);
   endproperty
   a_aea_rise: assert property (p_aea_rise) else $error("A almost-empty rose wrongly");

   property p_c_partial;
      c_take && !c_fin && !a_pop |=> $stable(ca_level_reg);
   endproperty
   a_c_partial: assert property (p_c_partial) else $error("Partial C write moved level");

   property p_afa_rise;
      $rose(PORT_A_ALMOST_FULL_N_OUT) |-> $past(a_edge);
   endproperty
   a_afa_rise: assert property (p_afa_rise) else $error("A almost-full rose off an A edge");

   property p_b_partial;
      b_take && !b_fin && !a_push |=> $stable(ab_level_reg);
   endproperty
   a_b_partial: assert property (p_b_partial) else $error("Partial B read moved level");

   property p_afc_rise;
      $rose(PORT_C_ALMOST_FULL_N_OUT) |-> $past(c_edge);
   endproperty
   a_afc_rise: assert property (p_afc_rise) else $error("C almost-full rose off a C edge");

   property p_afc_falls;
      c_fin && (ca_level_next >= af_mark) |=> !PORT_C_ALMOST_FULL_N_OUT;
   endproperty
   a_afc_falls: assert property (p_afc_falls) else $error("C almost-full not low");

   property p_mbx_b_word;
      b_mbx_rd && PORT_B_SIZE_IN == BMF_SIZE_WORD |=> PORT_B_DATA_OUT == $past(mailbox_ab_reg);
   endproperty
   a_mbx_b_word: assert property (p_mbx_b_word) else $error("Mailbox AB not on B");

   property p_mbx_a_byte;
      a_mbx_rd && !a_pop && PORT_C_SIZE_IN == BMF_SIZE_BYTE |=> PORT_A_DATA_OUT[35:27] == 9'h0;
   endproperty
   a_mbx_a_byte: assert property (p_mbx_a_byte) else $error("Byte mailbox upper lanes set");

   property p_mbx_flag;
      a_mbx_wr |=> !MAILBOX_AB_FULL_N_OUT ##0 mailbox_ab_reg[8:0] == $past(p.a_data[8:0]);
   endproperty
   a_mbx_flag: assert property (p_mbx_flag) else $error("Mailbox AB flag or data wrong");

   property p_level_cap;
      ab_level_reg <= DEPTH_L && ca_level_reg <= DEPTH_L;
   endproperty
   a_level_cap: assert property (p_level_cap) else $error("Level above depth");

   c_ab_fin:  cover property (b_fin);
   c_ca_full: cover property (ca_level_reg == DEPTH_L);
   c_mbx_rt:  cover property (a_mbx_wr ##[1:200] b_mbx_rd);
endmodule

// ### verification/bmf_port_master.sv
/* Port-side master model that drives the pin groups of ports A, B and C.
   Assumes the bench calls its tasks one at a time, from a falling edge. */
`timescale 1ns/1ns
module bmf_port_master
   import bmf_pkg::*;
(
   input  wire logic clk_in,
   output bmf_pins_t  pins_out
);
   initial pins_out = '0;
   // Port clocks stand low between accesses; pins settle 2 cycles before the rise
   task automatic pulse(input logic [2:0] clks);
      repeat (2) @(negedge clk_in);
      {pins_out.a_clk, pins_out.b_clk, pins_out.c_clk} = clks;
      repeat (5) @(negedge clk_in);
      {pins_out.a_clk, pins_out.b_clk, pins_out.c_clk} = 3'h0;
      repeat (5) @(negedge clk_in);
   endtask
   // Released data is inverted so that a stale value never passes for fresh
   task automatic port_a(input logic sn, dir, mbx, input logic [BMF_LONG_W-1:0] d);
      {pins_out.a_sel_n, pins_out.a_dir, pins_out.a_mbx, pins_out.a_en} = {sn, dir, mbx, 1'b1};
      pins_out.a_data = d;
      pulse(3'h4);
      pins_out.a_data = ~d;
   endtask
   task automatic port_b(input logic sn, mbx);
      {pins_out.b_sel_n, pins_out.b_mbx, pins_out.b_en} = {sn, mbx, 1'b1};
      pulse(3'h2);
   endtask
   task automatic port_c(input logic en, mbx, input logic [BMF_NARROW_W-1:0] d);
      {pins_out.c_en, pins_out.c_mbx, pins_out.c_data} = {en, mbx, d};
      pulse(3'h1);
      pins_out.c_data = ~d;
   endtask
endmodule

// ### verification/tb_bmf_queue.sv
/* Self-checking bench: queue flags, bus matching and mailboxes of the dual queue.
   Assumes the port master model and a 50 MHz system clock. */
`timescale 1ns/1ns
module tb_bmf_queue;
   import bmf_pkg::*;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   bmf_size_t               bsz = BMF_SIZE_WORD;
   bmf_size_t               csz = BMF_SIZE_WORD;
   bmf_pins_t               p;
   logic [BMF_LONG_W-1:0]   a_q;
   logic [BMF_NARROW_W-1:0] b_q;
   logic [17:0]             m;
   logic                    oe_n, aeb, aea, afa, afc, mab, mca;
   logic [35:0]             lw [2];
   int                      num_errors = 0;
   int                      comparisons = 0;
   always #10 clk = ~clk;
   bmf_port_master i_bmf_port_master (.clk_in(clk), .pins_out(p));
   bmf_queue #(.DEPTH(256)) i_bmf_queue (
      .CLK_SYS_IN(clk), .RESET_IN(rst), .CE_IN(1'b1), .PORT_A_CLOCK_IN(p.a_clk),
      .PORT_A_SELECT_N_IN(p.a_sel_n), .PORT_A_DIRECTION_IN(p.a_dir),
      .PORT_A_MAILBOX_SELECT_IN(p.a_mbx), .PORT_A_ENABLE_IN(p.a_en), .PORT_A_DATA_IN(p.a_data),
      .PORT_A_DATA_OUT(a_q), .PORT_A_DATA_OE_N_OUT(oe_n), .PORT_B_CLOCK_IN(p.b_clk),
      .PORT_B_SELECT_N_IN(p.b_sel_n), .PORT_B_MAILBOX_SELECT_IN(p.b_mbx),
      .PORT_B_ENABLE_IN(p.b_en), .PORT_B_SIZE_IN(bsz), .PORT_B_DATA_OUT(b_q),
      .PORT_C_CLOCK_IN(p.c_clk), .PORT_C_MAILBOX_SELECT_IN(p.c_mbx), .PORT_C_ENABLE_IN(p.c_en),
      .PORT_C_SIZE_IN(csz), .PORT_C_DATA_IN(p.c_data),
      .ALMOST_EMPTY_OFFSET_IN(9'h002), .ALMOST_FULL_OFFSET_IN(9'h0fd),
      .PORT_B_ALMOST_EMPTY_N_OUT(aeb), .PORT_A_ALMOST_EMPTY_N_OUT(aea),
      .PORT_A_ALMOST_FULL_N_OUT(afa), .PORT_C_ALMOST_FULL_N_OUT(afc),
      .MAILBOX_AB_FULL_N_OUT(mab), .MAILBOX_CA_FULL_N_OUT(mca));
   task automatic check(input logic [35:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
   // Offsets give almost-empty below 3 long words and almost-full from 3 long words
   initial begin
      lw[0] = 36'h987654321;
      lw[1] = 36'h123456789;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check({aeb, aea, afa, afc, mab, mca, oe_n}, 7'h1f);
      for (int i = 0; i < 3; i++) i_bmf_port_master.port_a(1'b0, 1'b1, 1'b0, lw[i % 2]);
      check(afa, 1'b0);
      check(aeb, 1'b0);
      i_bmf_port_master.port_b(1'b1, 1'b0);
      check(aeb, 1'b1);
      for (int s = 0; s < 2; s++) begin
         bsz = s ? BMF_SIZE_WORD : BMF_SIZE_BYTE;
         m = s ? 18'h3ffff : 18'h001ff;
         for (int k = 0; k < (s ? 2 : 4); k++) begin
            i_bmf_port_master.port_b(1'b0, 1'b0);
            check(b_q & m, 18'(lw[s] >> ((s ? 18 : 9) * k)) & m);
            check(aeb, s == 0 && k < 3);
            i_bmf_port_master.port_a(1'b1, 1'b0, 1'b0, 36'h0);
            check(afa, !(s == 0 && k < 3));
         end
      end
      for (int j = 0; j < 8; j++) begin
         csz = (j > 3) ? BMF_SIZE_BYTE : BMF_SIZE_WORD;
         i_bmf_port_master.port_c(1'b1, 1'b0, 18'h0a5a0 + 18'(j));
         check(afc, j != 7);
      end
      i_bmf_port_master.port_a(1'b1, 1'b0, 1'b0, 36'h0);
      check(aea, 1'b1);
      i_bmf_port_master.port_a(1'b0, 1'b0, 1'b0, 36'h0);
      check(a_q, {18'h0a5a1, 18'h0a5a0});
      check(oe_n, 1'b0);
      check(aea, 1'b0);
      i_bmf_port_master.port_c(1'b0, 1'b0, 18'h0);
      check(afc, 1'b1);
      for (int s = 0; s < 2; s++) begin
         bsz = bmf_size_t'(s);
         csz = bmf_size_t'(s);
         m = s ? 18'h001ff : 18'h3ffff;
         i_bmf_port_master.port_a(1'b0, 1'b1, 1'b1, 36'hfedcba987);
         check(mab, 1'b0);
         i_bmf_port_master.port_b(1'b0, 1'b1);
         check(b_q & m, 18'h3a987 & m);
         check(mab, 1'b1);
         i_bmf_port_master.port_c(1'b1, 1'b1, 18'h2c3d5);
         check(mca, 1'b0);
         i_bmf_port_master.port_a(1'b0, 1'b0, 1'b1, 36'h0);
         check(a_q & {m, 18'h0}, {18'h2c3d5 & m, 18'h0});
         check(mca, 1'b1);
      end
      summarize();
   end
endmodule
